//--- include/fcs_pkg.sv
package fcs_pkg;

  // ==========================================================================
  // Register map (word offsets on the byte address)
  // ==========================================================================
  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_MODE      = 8'h04;
  localparam logic [7:0] ADDR_STACK     = 8'h08;
  localparam logic [7:0] ADDR_INT_STAT  = 8'h0C;
  localparam logic [7:0] ADDR_INT_EN    = 8'h10;
  localparam logic [7:0] ADDR_INT_CLR   = 8'h14;
  localparam logic [7:0] ADDR_CTX_STAT  = 8'h18;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int CTRL_EN_BIT      = 0;
  localparam int MODE_FZ_BIT      = 0;
  localparam int MODE_HALF_BIT    = 1;
  localparam int MODE_NAN_BIT     = 2;
  localparam int MODE_RND_LSB     = 3;
  localparam int CTX_ACTIVE_BIT   = 0;
  localparam int CTX_SAVED_BIT    = 1;
  localparam int CTX_RESERVED_BIT = 2;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic       RST_ENABLE = 1'b0;
  localparam logic [4:0] RST_MODE   = 5'h00;
  localparam logic [5:0] RST_INT_EN = 6'h00;

  // ==========================================================================
  // Frame sizes in words
  // ==========================================================================
  localparam logic [4:0] FRAME_INT_WORDS = 5'h08;
  localparam logic [4:0] FRAME_FP_WORDS  = 5'h1A;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [1:0] {
    FCS_RND_NEAREST  = 2'b00,
    FCS_RND_UP_INF   = 2'b01,
    FCS_RND_DOWN_INF = 2'b10,
    FCS_RND_ZERO     = 2'b11
  } fcs_round_t;

  typedef enum logic [1:0] {
    FCS_STACK_LAZY = 2'b00,
    FCS_STACK_OFF  = 2'b01,
    FCS_STACK_ON   = 2'b10
  } fcs_stack_t;

  localparam fcs_stack_t RST_STACK = FCS_STACK_LAZY;

  // Exception flag order in status, enable and clear registers
  typedef struct packed {
    logic inexact;
    logic in_denormal;
    logic invalid;
    logic div_zero;
    logic overflow;
    logic underflow;
  } fcs_exc_t;

  // Arithmetic mode bundle handed to the datapath
  typedef struct packed {
    logic       flush_zero_on;
    logic       half_format_alt;
    logic       nan_canonical;
    fcs_round_t round_mode;
  } fcs_mode_t;

  // Exception entry directives to the core
  typedef struct packed {
    logic       reserve_fp;
    logic       store_fp;
    logic [4:0] frame_words;
  } fcs_entry_t;

endpackage

//--- rtl/fcs_fpu_ctrl.sv
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
// Operation
// - Disabled unit blocks instructions, raises fault
// - Enabled unit lets instructions execute
// - Flush-to-zero off default, on zeros tiny
// - Half format selects IEEE or alternative
// - NaN results propagate or give default
// - Four-way rounding mode, nearest default
// - Lazy entry reserves space, writes nothing
// - Lazy first instruction stores context first
// - Lazy return restores only if saved
// - Stacking off: no reserve, no save
// - Stacking on: reserve, save, restore
// - Frame 8 words, 26 with fp
// - Unit disabled out of reset
// - Default context handling is lazy
// - Six exceptions, each enableable interrupt
module fcs_fpu_ctrl (
  // Clock and reset
  input  wire logic                    i_ref_clk,
  input  wire logic                    i_resetn,
  // Register port
  input  wire logic [7:0]              i_reg_addr,
  input  wire logic [31:0]             i_reg_wdata,
  input  wire logic                    i_reg_wr,
  input  wire logic                    i_reg_rd,
  output logic [31:0]                  o_reg_rdata,
  // Pipeline issue
  input  wire logic                    i_fp_issue,
  output logic                         o_fp_go,
  output logic                         o_no_coprocessor_fault,
  output logic                         o_lazy_store_req,
  input  wire logic                    i_lazy_store_done,
  // Exception entry and return
  input  wire logic                    i_exc_entry,
  input  wire logic                    i_exc_return,
  output fcs_pkg::fcs_entry_t          o_entry,
  output logic                         o_restore_fp,
  // Datapath modes and exceptions
  output fcs_pkg::fcs_mode_t           o_mode,
  input  wire fcs_pkg::fcs_exc_t       i_exc_event,
  // Interrupt
  output logic                         o_irq
);

  // ==========================================================================
  // State
  // ==========================================================================
  logic                 fp_enable;
  fcs_pkg::fcs_mode_t   mode;
  fcs_pkg::fcs_stack_t  stack_sel;
  fcs_pkg::fcs_exc_t    int_stat;
  fcs_pkg::fcs_exc_t    int_en;
  logic                 ctx_active;
  logic                 ctx_reserved;
  logic                 ctx_saved;
  logic                 store_busy;
  logic                 wr_ctrl;
  logic                 wr_mode;
  logic                 wr_stack;
  logic                 wr_clr;
  logic                 lazy_pending;

  // Register write decode
  assign wr_ctrl  = i_reg_wr && (i_reg_addr == fcs_pkg::ADDR_CTRL);
  assign wr_mode  = i_reg_wr && (i_reg_addr == fcs_pkg::ADDR_MODE);
  assign wr_stack = i_reg_wr && (i_reg_addr == fcs_pkg::ADDR_STACK);
  assign wr_clr   = i_reg_wr && (i_reg_addr == fcs_pkg::ADDR_INT_CLR);

  // ==========================================================================
  // Enable
  // ==========================================================================
  // Unit enable, off after reset
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      fp_enable <= fcs_pkg::RST_ENABLE;
    end else if (wr_ctrl) begin
      fp_enable <= i_reg_wdata[fcs_pkg::CTRL_EN_BIT];
    end
  end

  // ==========================================================================
  // Arithmetic modes
  // ==========================================================================
  // Mode fields; datapath samples them per instruction, so settings written
  // after the first instruction affect later ones only
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      mode <= fcs_pkg::fcs_mode_t'(fcs_pkg::RST_MODE);
    end else if (wr_mode) begin
      mode.flush_zero_on   <= i_reg_wdata[fcs_pkg::MODE_FZ_BIT];
      mode.half_format_alt <= i_reg_wdata[fcs_pkg::MODE_HALF_BIT];
      mode.nan_canonical   <= i_reg_wdata[fcs_pkg::MODE_NAN_BIT];
      mode.round_mode      <= fcs_pkg::fcs_round_t'(
                                i_reg_wdata[fcs_pkg::MODE_RND_LSB +: 2]);
    end
  end

  assign o_mode = mode;

  // ==========================================================================
  // Stacking selection
  // ==========================================================================
  // One code holds the choice, so selections cannot overlap; unused code
  // is ignored to keep the previous choice
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      stack_sel <= fcs_pkg::RST_STACK;
    end else if (wr_stack && (i_reg_wdata[1:0] != 2'b11)) begin
      stack_sel <= fcs_pkg::fcs_stack_t'(i_reg_wdata[1:0]);
    end
  end

  // ==========================================================================
  // Exception entry directives
  // ==========================================================================
  // Combinational so the core sees the frame shape in the entry cycle
  always_comb begin
    o_entry.reserve_fp  = 1'b0;
    o_entry.store_fp    = 1'b0;
    o_entry.frame_words = fcs_pkg::FRAME_INT_WORDS;
    unique case (stack_sel)
      fcs_pkg::FCS_STACK_LAZY: begin
        o_entry.reserve_fp  = 1'b1;
        o_entry.frame_words = fcs_pkg::FRAME_FP_WORDS;
      end
      fcs_pkg::FCS_STACK_ON: begin
        o_entry.reserve_fp  = 1'b1;
        o_entry.store_fp    = 1'b1;
        o_entry.frame_words = fcs_pkg::FRAME_FP_WORDS;
      end
      fcs_pkg::FCS_STACK_OFF: begin
        o_entry.reserve_fp  = 1'b0;
      end
      default: begin
        o_entry.reserve_fp  = 1'b0;
      end
    endcase
  end

  // ==========================================================================
  // Handler context tracking
  // ==========================================================================
  // Tracks one handler level; nested frames are the core's concern
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      ctx_active   <= 1'b0;
      ctx_reserved <= 1'b0;
      ctx_saved    <= 1'b0;
    end else if (i_exc_entry) begin
      ctx_active   <= 1'b1;
      ctx_reserved <= (stack_sel == fcs_pkg::FCS_STACK_LAZY);
      ctx_saved    <= (stack_sel == fcs_pkg::FCS_STACK_ON);
    end else if (i_exc_return) begin
      ctx_active   <= 1'b0;
      ctx_reserved <= 1'b0;
      ctx_saved    <= 1'b0;
    end else if (store_busy && i_lazy_store_done) begin
      ctx_reserved <= 1'b0;
      ctx_saved    <= 1'b1;
    end
  end

  // Restore on return only when a context sits in the frame
  assign o_restore_fp = i_exc_return && ctx_saved;

  // ==========================================================================
  // Issue gating and lazy store
  // ==========================================================================
  assign lazy_pending = ctx_active && ctx_reserved && !ctx_saved;

  // Store in flight holds the instruction until the frame is written
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      store_busy <= 1'b0;
    end else if (i_exc_entry || i_exc_return || i_lazy_store_done) begin
      store_busy <= 1'b0;
    end else if (i_fp_issue && fp_enable && lazy_pending) begin
      store_busy <= 1'b1;
    end
  end

  // Handshake outputs; the core re-presents the issue until o_fp_go or o_no_coprocessor_fault
  assign o_no_coprocessor_fault = i_fp_issue && !fp_enable;
  assign o_lazy_store_req       = i_fp_issue && fp_enable && lazy_pending;
  assign o_fp_go                = i_fp_issue && fp_enable && !lazy_pending;

  // ==========================================================================
  // Exception interrupts
  // ==========================================================================
  // Sticky flags; a new event beats a clear in the same cycle
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      int_stat <= '0;
    end else begin
      int_stat <= (int_stat & ~(wr_clr ? fcs_pkg::fcs_exc_t'(i_reg_wdata[5:0]) : '0))
                  | i_exc_event;
    end
  end

  // Per-source enable
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      int_en <= fcs_pkg::fcs_exc_t'(fcs_pkg::RST_INT_EN);
    end else if (i_reg_wr && (i_reg_addr == fcs_pkg::ADDR_INT_EN)) begin
      int_en <= fcs_pkg::fcs_exc_t'(i_reg_wdata[5:0]);
    end
  end

  assign o_irq = |(int_stat & int_en);

  // ==========================================================================
  // Read back
  // ==========================================================================
  // Data in the cycle after the strobe only; unmapped reads return zero
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      o_reg_rdata <= '0;
    end else if (i_reg_rd) begin
      unique case (i_reg_addr)
        fcs_pkg::ADDR_CTRL:     o_reg_rdata <= {31'h0, fp_enable};
        fcs_pkg::ADDR_MODE:     o_reg_rdata <= {27'h0, mode.round_mode, mode.nan_canonical,
                                                mode.half_format_alt, mode.flush_zero_on};
        fcs_pkg::ADDR_STACK:    o_reg_rdata <= {30'h0, stack_sel};
        fcs_pkg::ADDR_INT_STAT: o_reg_rdata <= {26'h0, int_stat};
        fcs_pkg::ADDR_INT_EN:   o_reg_rdata <= {26'h0, int_en};
        fcs_pkg::ADDR_CTX_STAT: o_reg_rdata <= {29'h0, ctx_reserved, ctx_saved, ctx_active};
        default:                o_reg_rdata <= '0;
      endcase
    end else begin
      o_reg_rdata <= '0;
    end
  end

endmodule

//--- tb/fcs_fpu_ctrl_chk.sv
`timescale 1ns/1ps
// ==========================================================
// Port checker
module fcs_fpu_ctrl_chk (
  input wire logic                i_ref_clk,
  input wire logic                i_resetn,
  input wire logic                i_reg_wr,
  input wire logic                i_fp_issue,
  input wire logic                o_fp_go,
  input wire logic                o_no_coprocessor_fault,
  input wire logic                o_lazy_store_req,
  input wire logic                i_lazy_store_done,
  input wire logic                i_exc_return,
  input wire fcs_pkg::fcs_entry_t o_entry,
  input wire logic                o_restore_fp,
  input wire fcs_pkg::fcs_mode_t  o_mode,
  input wire logic                o_irq
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);
  // Lazy store steps: pending, then done with issue still held
  sequence s_pend; i_fp_issue && o_lazy_store_req; endsequence
  sequence s_done; i_lazy_store_done ##1 i_fp_issue; endsequence
  property p_fault; o_no_coprocessor_fault |-> i_fp_issue && !o_fp_go; endproperty
  property p_go; o_fp_go |-> i_fp_issue && !o_no_coprocessor_fault; endproperty
  property p_hold; s_pend |-> !o_fp_go; endproperty
  property p_after; s_done |-> !o_lazy_store_req; endproperty
  property p_frame; o_entry.frame_words == (o_entry.reserve_fp ?
    fcs_pkg::FRAME_FP_WORDS : fcs_pkg::FRAME_INT_WORDS); endproperty
  property p_store; o_entry.store_fp |-> o_entry.reserve_fp; endproperty
  property p_restore; o_restore_fp |-> i_exc_return; endproperty
  property p_mode; !i_reg_wr |=> $stable(o_mode); endproperty
  property p_irq; o_irq && !i_reg_wr |=> o_irq; endproperty
  a_fault: assert property (p_fault) else $error("fault without blocked issue");
  a_go: assert property (p_go) else $error("go beside fault");
  a_hold: assert property (p_hold) else $error("go before lazy store");
  a_after: assert property (p_after) else $error("store asked twice");
  a_frame: assert property (p_frame) else $error("frame size wrong");
  a_store: assert property (p_store) else $error("store without space");
  a_restore: assert property (p_restore) else $error("restore off return");
  a_mode: assert property (p_mode) else $error("mode moved alone");
  a_irq: assert property (p_irq) else $error("irq dropped alone");
endmodule
bind fcs_fpu_ctrl fcs_fpu_ctrl_chk i_fcs_fpu_ctrl_chk (.i_ref_clk, .i_resetn, .i_reg_wr,
  .i_fp_issue, .o_fp_go, .o_no_coprocessor_fault, .o_lazy_store_req, .i_lazy_store_done,
  .i_exc_return, .o_entry, .o_restore_fp, .o_mode, .o_irq);

//--- tb/fcs_core_model.sv
`timescale 1ns/1ps
// ==========================================================
// Core pipeline stand-in
module fcs_core_model (
  // Clock, reset, bench command
  input wire logic       i_ref_clk,
  input wire logic       i_resetn,
  input wire logic       i_cmd_issue,
  input wire logic [3:0] i_store_delay,
  // Block answers
  input wire logic       i_fp_go,
  input wire logic       i_fault,
  input wire logic       i_store_req,
  // To block
  output logic           o_fp_issue,
  output logic           o_store_done
);
  logic [3:0] cnt;
  // Issue held until answered; context written after a delay
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      o_fp_issue <= 1'b0;
      o_store_done <= 1'b0;
      cnt <= 4'h0;
    end else begin
      o_store_done <= 1'b0;
      if (i_cmd_issue) o_fp_issue <= 1'b1;
      else if (o_fp_issue && (i_fp_go || i_fault)) o_fp_issue <= 1'b0;
      if (o_fp_issue && i_store_req && !o_store_done) begin
        cnt <= (cnt == i_store_delay) ? 4'h0 : cnt + 4'h1;
        o_store_done <= (cnt == i_store_delay);
      end
    end
  end
endmodule

//--- tb/tb_fcs_fpu_ctrl.sv
`timescale 1ns/1ps
// ==========================================================
// Self-checking bench
module tb_fcs_fpu_ctrl;
  logic clk, rstn, wr, rd, cmd, ent, ret, go, flt, req, iss, dn, irq, rf, g, f, s;
  logic [7:0]          addr;
  logic [31:0]         wd, rdat, v;
  logic [3:0]          dly;
  logic [5:0]          ev;
  fcs_pkg::fcs_entry_t e;
  fcs_pkg::fcs_mode_t  m;
  int                  num_errors, n_checks;
  fcs_fpu_ctrl i_fcs_fpu_ctrl (.i_ref_clk(clk), .i_resetn(rstn), .i_reg_addr(addr),
    .i_reg_wdata(wd), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdat), .i_fp_issue(iss),
    .o_fp_go(go), .o_no_coprocessor_fault(flt), .o_lazy_store_req(req),
    .i_lazy_store_done(dn), .i_exc_entry(ent), .i_exc_return(ret), .o_entry(e),
    .o_restore_fp(rf), .o_mode(m), .i_exc_event(ev), .o_irq(irq));
  fcs_core_model i_fcs_core_model (.i_ref_clk(clk), .i_resetn(rstn), .i_cmd_issue(cmd),
    .i_store_delay(dly), .i_fp_go(go), .i_fault(flt), .i_store_req(req),
    .o_fp_issue(iss), .o_store_done(dn));
  // Clock, 4 ns period
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk); addr <= a; wd <= d; wr <= 1'b1;
    @(posedge clk); wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rreg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk); addr <= a; rd <= 1'b1;
    @(posedge clk); rd <= 1'b0;
    #1 d = rdat;
  endtask
  // Entry or return pulse; restore is sampled while the pulse stands
  task automatic exc(input logic r, output logic rs);
    @(posedge clk); ent <= !r; ret <= r;
    #1 rs = rf;
    @(posedge clk); ent <= 1'b0; ret <= 1'b0;
  endtask
  // One instruction through the core model, bounded wait
  task automatic issue(input logic [3:0] d, output logic og, output logic of, output logic os);
    os = 1'b0;
    @(posedge clk); dly <= d; cmd <= 1'b1;
    @(posedge clk); cmd <= 1'b0;
    for (int i = 0; i < 50; i++) begin
      #1 os = os | req;
      og = go; of = flt;
      if (go || flt) return;
      @(posedge clk);
    end
    num_errors++;
    tally_and_finish();
  endtask
  task automatic t_reset();
    rreg(fcs_pkg::ADDR_CTRL, v); chk(v, 0);
    rreg(fcs_pkg::ADDR_STACK, v); chk(v, 0);
    chk(32'(e), 32'h0000_005A); chk(32'(m), 0);
    issue(4'h0, g, f, s); chk(f, 1); chk(g, 0);
    $display("t_reset done");
  endtask
  task automatic t_modes();
    wreg(fcs_pkg::ADDR_CTRL, 1); issue(4'h0, g, f, s); chk({g, f}, 2'b10);
    for (int i = 0; i < 4; i++) begin
      v = 32'(i * 8 + 7 - i);
      wreg(fcs_pkg::ADDR_MODE, v);
      #1 chk(32'(m), 32'({v[0], v[1], v[2], v[4:3]}));
    end
    wreg(fcs_pkg::ADDR_CTRL, 0); issue(4'h0, g, f, s); chk(f, 1);
    wreg(fcs_pkg::ADDR_CTRL, 1);
    $display("t_modes done");
  endtask
  // Off, on, refused code 3, lazy; restore follows stored context
  task automatic t_stack();
    logic [7:0] tbl [4] = '{8'h08, 8'h7A, 8'h7A, 8'h5A};
    for (int i = 0; i < 4; i++) begin
      wreg(fcs_pkg::ADDR_STACK, (i + 1) % 4);
      #1 chk(32'(e), 32'(tbl[i]));
      exc(0, f); exc(1, g); chk(g, tbl[i][5]);
    end
    $display("t_stack done");
  endtask
  task automatic t_lazy();
    exc(0, g);
    rreg(fcs_pkg::ADDR_CTX_STAT, v); chk(v, 5);
    issue(4'h3, g, f, s); chk({s, g}, 2'b11);
    rreg(fcs_pkg::ADDR_CTX_STAT, v); chk(v, 3);
    exc(1, g); chk(g, 1);
    $display("t_lazy done");
  endtask
  task automatic t_irq();
    @(posedge clk); ev <= 6'h20; @(posedge clk); ev <= 6'h00;
    rreg(fcs_pkg::ADDR_INT_STAT, v); chk(v, 32'h20); chk(irq, 0);
    wreg(fcs_pkg::ADDR_INT_EN, 32'h21); #1 chk(irq, 1);
    wreg(fcs_pkg::ADDR_INT_CLR, 32'h20); #1 chk(irq, 0);
    @(posedge clk); ev <= 6'h01; @(posedge clk); ev <= 6'h00; #1 chk(irq, 1);
    rreg(8'h20, v); chk(v, 0);
    $display("t_irq done");
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Reset for 20 cycles, then each scenario
  initial begin
    {rstn, wr, rd, cmd, ent, ret, addr, wd, dly, ev} = '0;
    num_errors = 0;
    n_checks = 0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    t_reset(); t_modes(); t_stack(); t_lazy(); t_irq();
    tally_and_finish();
  end
endmodule
